// ===== logic/sdr_cfg.svh
/*
  Named constants of the squib diagnostic read-back block: command codes,
  byte layout and reset values.
  Assumes it is included by bare name from every file that uses them.
*/
`ifndef SDR_CFG_SVH
`define SDR_CFG_SVH

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define SDR_CMD_NOP        8'h00
`define SDR_CMD_TIME_1A    8'h70
`define SDR_CMD_TIME_1B    8'h71
`define SDR_CMD_TIME_2A    8'h72
`define SDR_CMD_TIME_2B    8'h73
`define SDR_CMD_CUR_LIMIT  8'h79
`define SDR_CMD_THERMAL    8'h7F
`define SDR_CMD_SUPPLY     8'hC0
`define SDR_CMD_SHORT      8'hC1
`define SDR_CMD_CONT       8'hC2
`define SDR_CMD_OPEN_SHORT 8'hC3
`define SDR_CMD_FIRE_VOLT  8'hC5
`define SDR_CMD_LEVELS     8'hC6
`define SDR_CMD_ARM_ONE    8'hA0
`define SDR_CMD_ARM_TWO    8'hA1
`define SDR_CMD_ARM_ALL    8'hA2

// ----------------------------------------------------------------------
// byte layout and reset values
// ----------------------------------------------------------------------
`define SDR_BYTE_MSB       7
`define SDR_ZERO_BYTE      8'h00
`define SDR_ZERO_NIBBLE    4'h0
`define SDR_ZERO_TRIPLE    3'h0
`define SDR_DONT_CARE      2'h0
`define SDR_CS_SYNC_RESET  3'h7
`define SDR_LINK_IDLE      10'h200

`endif

// ===== logic/sdr_pkg.sv
/*
  Types shared by the read-back block and its serial link shifter.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sdr_pkg;

  // index 0 = channel 1A .. 3 = 2B; supply index 0 = supply 1
  typedef struct packed {
    logic [7:0] time1a;
    logic [7:0] time1b;
    logic [7:0] time2a;
    logic [7:0] time2b;
    logic [3:0] curLimit;
    logic [3:0] thermLow;
    logic [3:0] thermHigh;
    logic [1:0] safingLow;
    logic [1:0] safingHigh;
    logic [1:0] diagHigh;
    logic [1:0] diagLow;
    logic [3:0] noGnd;
    logic [3:0] noBatt;
    logic [3:0] lowCont;
    logic [3:0] openNoGnd;
    logic [3:0] openNoBatt;
    logic       fireBTested;
    logic       fireVHigh;
    logic       fireVLow;
    logic [3:0] diagLevel2;
    logic [3:0] diagLevel1;
  } sdr_status_type;

  typedef struct packed {
    logic [2:0]     csSync;
    logic [1:0]     fen1Sync;
    logic [1:0]     fen2Sync;
    logic [2:0]     strobeSync;
    sdr_status_type statusMeta;
    sdr_status_type statusSync;
    sdr_status_type store;
    logic [7:0]     respWord;
    logic [7:0]     lastCommand;
    logic           armRequest;
  } sdr_main_type;

  typedef struct packed {
    logic       oe_b;
    logic       miso;
    logic [7:0] txShift;
  } sdr_link_type;

endpackage

// ===== logic/sdr_link_shifter.sv
/*
  Serial link shifter: takes command bits in and puts answer bits out on
  the host's serial clock.
  Assumes the host clocks exactly 8 rising edges per frame with chip
  select low, and no edges while chip select is high.
*/
`timescale 1ns/1ps
`include "sdr_cfg.svh"

module sdr_link_shifter
  import sdr_pkg::*;
(
  input  wire logic       sclk,
  input  wire logic       csB,
  input  wire logic       mosi,
  input  wire logic [7:0] respWord,
  output logic      [7:0] rxWord,
  output logic            miso,
  output logic            misoOe_b
);

  sdr_link_type lk;
  sdr_link_type next_lk;
  logic [7:0]   next_rxWord;

  // ----------------------------------------------------------------------
  // answer shifter
  // ----------------------------------------------------------------------
  // oe_b still high marks the first edge of a frame; respWord has been
  // stable since the previous frame ended, so it is safe to load here
  always_comb
  begin
    next_lk      = lk;
    next_lk.oe_b = 1'b0;
    if (lk.oe_b)
    begin
      next_lk.miso    = respWord[`SDR_BYTE_MSB];  // [RL1]
      next_lk.txShift = respWord << 1;
    end
    else
    begin
      next_lk.miso    = lk.txShift[`SDR_BYTE_MSB];  // [RL1]
      next_lk.txShift = lk.txShift << 1;
    end
  end

  // chip select high ends the frame, since no edge follows it
  always_ff @(posedge sclk or posedge csB)
  begin
    if (csB)
      lk <= `SDR_LINK_IDLE;
    else
      lk <= next_lk;
  end

  // ----------------------------------------------------------------------
  // command shifter
  // ----------------------------------------------------------------------
  // no reset: the word is only read after a full frame has filled it
  always_comb
  begin
    next_rxWord = {rxWord[`SDR_BYTE_MSB-1:0], mosi};
  end

  always_ff @(posedge sclk)
  begin
    rxWord <= next_rxWord;
  end

  assign miso     = lk.miso;
  assign misoOe_b = lk.oe_b;

endmodule

// ===== logic/squib_diag_readback.sv
/*
  Squib diagnostic read-back: decodes 8-bit diagnostic commands from the
  serial link and prepares the status byte sent on the next transfer.
  Assumes the measurement circuits drive the status inputs and pulse
  resultStrobe when a new set of results is ready; status pins are
  asynchronous to clk.
*/
// Behaviour
// RL1 - selected status byte goes out on the next transfer; host sends another command
// RL2 - codes 70..73 return current time of 1A, 1B, 2A, 2B, MSB first
// RL3 - code 79 returns zero upper nibble, current-limit flags 2B..1A below
// RL4 - code 7F returns low/high thermal flag pairs, 2B highest down to 1A
// RL5 - code C0 returns safing low/high, supply high/low; supply 2 upper nibble
// RL6 - code C1 returns ground-short/battery-short pairs, 2B highest
// RL7 - code C2 returns zero upper nibble, low-side continuity 2B..1A below
// RL8 - code C3 returns open-harness short pairs, same layout as C1
// RL9 - code C5 returns zeros, supply B tested, don't-cares, high, low flags
// RL10 - code C6 returns supply 2 levels high nibble, supply 1 levels low
// RL11 - code 00 changes nothing and returns an all-zero byte
// RL12 - an accepted arm command clears all stored diagnostic results; a strobe rise in the same cycle loads fresh results instead
`timescale 1ns/1ps
`include "sdr_cfg.svh"

module squib_diag_readback
  import sdr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       sclk,
  input  wire logic       csB,
  input  wire logic       mosi,
  input  wire logic       fireEnableOne,
  input  wire logic       fireEnableTwo,
  input  wire logic       resultStrobe,
  input  wire logic [7:0] channel1aTime,
  input  wire logic [7:0] channel1bTime,
  input  wire logic [7:0] channel2aTime,
  input  wire logic [7:0] channel2bTime,
  input  wire logic [3:0] currentLimit,
  input  wire logic [3:0] lowSideThermalFlag,
  input  wire logic [3:0] highSideThermalFlag,
  input  wire logic [1:0] safingSensorLow,
  input  wire logic [1:0] safingSensorHigh,
  input  wire logic [1:0] diagSupplyHigh,
  input  wire logic [1:0] diagSupplyLow,
  input  wire logic [3:0] noGroundShort,
  input  wire logic [3:0] noBatteryShort,
  input  wire logic [3:0] lowSideContinuity,
  input  wire logic [3:0] openNoGroundShort,
  input  wire logic [3:0] openNoBatteryShort,
  input  wire logic       firingSupplyBTested,
  input  wire logic       voltageHighFlag,
  input  wire logic       voltageLowFlag,
  input  wire logic [3:0] diagnosticSupply2Level,
  input  wire logic [3:0] diagnosticSupply1Level,
  output logic            miso,
  output logic            misoOe_b,
  output logic            armRequest,
  output logic      [7:0] lastCommand
);

  // ----------------------------------------------------------------------
  // state and local signals
  // ----------------------------------------------------------------------
  sdr_main_type   st;
  sdr_main_type   next_st;
  sdr_status_type liveStatus;
  logic [7:0]     rxWord;
  logic           frameEnd;
  logic           strobeRise;
  logic           fen1;
  logic           fen2;
  logic           armOk;
  logic           isArm;
  logic [7:0]     answer;

  // ----------------------------------------------------------------------
  // byte builders
  // ----------------------------------------------------------------------
  // interleaves two per-channel flag sets, channel 2B in bits 7:6
  function automatic logic [7:0] pairFlags(input logic [3:0] upper,
                                           input logic [3:0] lower);
    logic [7:0] res;
    res = `SDR_ZERO_BYTE;
    for (int ch = 0; ch < 4; ch++)
    begin
      res[2*ch+1] = upper[ch];
      res[2*ch]   = lower[ch];
    end
    return res;
  endfunction

  // one supply's nibble: safing low, safing high, supply high, supply low
  function automatic logic [3:0] supplyNibble(input sdr_status_type s,
                                              input int unsigned idx);
    return {s.safingLow[idx], s.safingHigh[idx], s.diagHigh[idx],
            s.diagLow[idx]};
  endfunction

  // ----------------------------------------------------------------------
  // gather status pins into one word
  // ----------------------------------------------------------------------
  // live values are raw pin levels and are only read through two flops
  always_comb
  begin
    liveStatus.time1a      = channel1aTime;
    liveStatus.time1b      = channel1bTime;
    liveStatus.time2a      = channel2aTime;
    liveStatus.time2b      = channel2bTime;
    liveStatus.curLimit    = currentLimit;
    liveStatus.thermLow    = lowSideThermalFlag;
    liveStatus.thermHigh   = highSideThermalFlag;
    liveStatus.safingLow   = safingSensorLow;
    liveStatus.safingHigh  = safingSensorHigh;
    liveStatus.diagHigh    = diagSupplyHigh;
    liveStatus.diagLow     = diagSupplyLow;
    liveStatus.noGnd       = noGroundShort;
    liveStatus.noBatt      = noBatteryShort;
    liveStatus.lowCont     = lowSideContinuity;
    liveStatus.openNoGnd   = openNoGroundShort;
    liveStatus.openNoBatt  = openNoBatteryShort;
    liveStatus.fireBTested = firingSupplyBTested;
    liveStatus.fireVHigh   = voltageHighFlag;
    liveStatus.fireVLow    = voltageLowFlag;
    liveStatus.diagLevel2  = diagnosticSupply2Level;
    liveStatus.diagLevel1  = diagnosticSupply1Level;
  end

  // ----------------------------------------------------------------------
  // events seen in the clk domain
  // ----------------------------------------------------------------------
  // only the second and third sync stages are looked at, never the first
  assign frameEnd   = st.csSync[1] & ~st.csSync[2];
  assign strobeRise = st.strobeSync[1] & ~st.strobeSync[2];
  assign fen1       = st.fen1Sync[1];
  assign fen2       = st.fen2Sync[1];

  // ----------------------------------------------------------------------
  // arm acceptance
  // ----------------------------------------------------------------------
  // an arm is taken only when the matching fire enable pins are high
  always_comb
  begin
    isArm = 1'b0;
    armOk = 1'b0;
    unique case (rxWord)
      `SDR_CMD_ARM_ONE:
      begin
        isArm = 1'b1;
        armOk = fen1;
      end
      `SDR_CMD_ARM_TWO:
      begin
        isArm = 1'b1;
        armOk = fen2;
      end
      `SDR_CMD_ARM_ALL:
      begin
        isArm = 1'b1;
        armOk = fen1 & fen2;
      end
      default:
      begin
        isArm = 1'b0;
        armOk = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // command decode: answer for the next transfer
  // ----------------------------------------------------------------------
  // unknown codes answer zero, which keeps a mistyped command harmless
  always_comb
  begin
    answer = `SDR_ZERO_BYTE;
    unique case (rxWord)
      `SDR_CMD_NOP:
        answer = `SDR_ZERO_BYTE;  // [RL11]
      `SDR_CMD_TIME_1A:
        answer = st.store.time1a;  // [RL2]
      `SDR_CMD_TIME_1B:
        answer = st.store.time1b;  // [RL2]
      `SDR_CMD_TIME_2A:
        answer = st.store.time2a;  // [RL2]
      `SDR_CMD_TIME_2B:
        answer = st.store.time2b;  // [RL2]
      `SDR_CMD_CUR_LIMIT:
        answer = {`SDR_ZERO_NIBBLE, st.store.curLimit};  // [RL3]
      `SDR_CMD_THERMAL:
        answer = pairFlags(st.store.thermLow, st.store.thermHigh);  // [RL4]
      `SDR_CMD_SUPPLY:
        answer = {supplyNibble(st.store, 1), supplyNibble(st.store, 0)};  // [RL5]
      `SDR_CMD_SHORT:
        answer = pairFlags(st.store.noGnd, st.store.noBatt);  // [RL6]
      `SDR_CMD_CONT:
        answer = {`SDR_ZERO_NIBBLE, st.store.lowCont};  // [RL7]
      `SDR_CMD_OPEN_SHORT:
        answer = pairFlags(st.store.openNoGnd, st.store.openNoBatt);  // [RL8]
      `SDR_CMD_FIRE_VOLT:
        answer = {`SDR_ZERO_TRIPLE, st.store.fireBTested, `SDR_DONT_CARE,
                  st.store.fireVHigh, st.store.fireVLow};  // [RL9]
      `SDR_CMD_LEVELS:
        answer = {st.store.diagLevel2, st.store.diagLevel1};  // [RL10]
      `SDR_CMD_ARM_ONE,
      `SDR_CMD_ARM_TWO,
      `SDR_CMD_ARM_ALL:
        answer = rxWord;  // arm codes are echoed
      default:
        answer = `SDR_ZERO_BYTE;
    endcase
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  // the command word is read only after chip select has been seen high
  // through the synchroniser, when the link clock no longer moves it
  always_comb
  begin
    next_st            = st;
    next_st.csSync     = {st.csSync[1:0], csB};
    next_st.fen1Sync   = {st.fen1Sync[0], fireEnableOne};
    next_st.fen2Sync   = {st.fen2Sync[0], fireEnableTwo};
    next_st.strobeSync = {st.strobeSync[1:0], resultStrobe};
    next_st.statusMeta = liveStatus;
    next_st.statusSync = st.statusMeta;
    next_st.armRequest = 1'b0;
    if (frameEnd)
    begin
      next_st.respWord    = answer;  // [RL1]
      next_st.lastCommand = rxWord;
      if (isArm && armOk)
      begin
        next_st.store      = '0;  // [RL12]
        next_st.armRequest = 1'b1;
      end
    end
    // a fresh result in the clearing cycle wins over the clear
    if (strobeRise)
    begin
      next_st.store = st.statusSync;
    end
    if (!rst_b)
    begin
      next_st        = '0;
      next_st.csSync = `SDR_CS_SYNC_RESET;  // avoids a false frame end
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    st <= next_st;
  end

  // ----------------------------------------------------------------------
  // link side
  // ----------------------------------------------------------------------
  // respWord crosses as a quiet word: it only changes between frames
  sdr_link_shifter u_link (
    .sclk     (sclk),
    .csB      (csB),
    .mosi     (mosi),
    .respWord (st.respWord),
    .rxWord   (rxWord),
    .miso     (miso),
    .misoOe_b (misoOe_b)
  );

  assign armRequest  = st.armRequest;
  assign lastCommand = st.lastCommand;

endmodule

// ===== verification/sdr_readback_chk.sv
/*
  checker: link idle levels, frame timing of commands and arm pulses.
  assumes it is bound onto squib_diag_readback and that fire enables
  settle long before any arm command.
*/
`timescale 1ns/1ps
`include "sdr_cfg.svh"

module sdr_readback_chk
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       sclk,
  input wire logic       csB,
  input wire logic       fireEnableOne,
  input wire logic       fireEnableTwo,
  input wire logic       miso,
  input wire logic       misoOe_b,
  input wire logic       armRequest,
  input wire logic [7:0] lastCommand
);
  // ----------------------------------------------------------------------
  // link pins
  // ----------------------------------------------------------------------
  chk_oe_idle: assert property (@(posedge clk) disable iff (!rst_b) csB |-> misoOe_b)
    else $error("answer driver enabled outside a frame");
  chk_miso_idle: assert property (@(posedge clk) disable iff (!rst_b) csB |-> !miso)
    else $error("answer line not low outside a frame");
  // link domain has no reset; a deselect ends any frame check
  chk_oe_frame: assert property (@(negedge sclk) disable iff (csB) !csB |-> !misoOe_b)
    else $error("answer driver off during a frame");
  // commands only land after a frame closes, never mid-frame
  chk_cmd_framed: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(lastCommand) |-> csB)
    else $error("command changed while selected");

  // ----------------------------------------------------------------------
  // arm handling
  // ----------------------------------------------------------------------
  chk_arm_single: assert property (@(posedge clk) disable iff (!rst_b)
    armRequest |=> !armRequest)
    else $error("arm pulse longer than one cycle");
  chk_arm_code: assert property (@(posedge clk) disable iff (!rst_b)
    armRequest |-> lastCommand inside {`SDR_CMD_ARM_ONE, `SDR_CMD_ARM_TWO, `SDR_CMD_ARM_ALL})
    else $error("arm pulse without an arm command");
  chk_arm_one_fen: assert property (@(posedge clk) disable iff (!rst_b)
    armRequest && lastCommand == `SDR_CMD_ARM_ONE |-> $past(fireEnableOne, 3))
    else $error("first pair armed without its enable");
  chk_arm_two_fen: assert property (@(posedge clk) disable iff (!rst_b)
    armRequest && lastCommand == `SDR_CMD_ARM_TWO |-> $past(fireEnableTwo, 3))
    else $error("second pair armed without its enable");
  chk_nop_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    lastCommand == `SDR_CMD_NOP |-> !armRequest)
    else $error("no-operation raised an arm pulse");
endmodule

bind squib_diag_readback sdr_readback_chk u_chk (
  .clk(clk), .rst_b(rst_b), .sclk(sclk), .csB(csB), .fireEnableOne(fireEnableOne),
  .fireEnableTwo(fireEnableTwo), .miso(miso), .misoOe_b(misoOe_b),
  .armRequest(armRequest), .lastCommand(lastCommand));

// ===== verification/sdr_host_model.sv
/*
  host model: serial master sending one command byte per frame.
  assumes callers run one frame at a time; the serial clock stands
  still between frames.
*/
`timescale 1ns/1ps

module sdr_host_model
(
  output logic      sclk,
  output logic      csB,
  output logic      mosi,
  input  wire logic miso
);
  // link starts selected for 1 ns with the clock parked low; the late rise of
  // chip select is the edge that parks the answer shifter at power-up
  initial
  begin
    sclk = 1'b0;
    csB  = 1'b0;
    mosi = 1'b0;
    #1;
    csB  = 1'b1;
  end

  // one frame; the answer to the previous command comes back meanwhile
  task automatic xfer(input logic [7:0] cmd, output logic [7:0] rx);
    #3.1;
    csB  = 1'b0;
    mosi = cmd[7];
    #7.5;
    for (int i = 7; i >= 0; i--)
    begin
      sclk = 1'b1;
      #7.5;
      sclk  = 1'b0;
      rx[i] = miso; // mid-bit sample on the falling edge
      if (i > 0)
        mosi = cmd[i-1];
      #7.5;
    end
    csB  = 1'b1;
    mosi = ~mosi; // no pull on the line, so the last bit never lingers
    #60;          // gap lets the answer settle before the next first edge
  endtask
endmodule

// ===== verification/squib_diag_readback_tb.sv
/*
  testbench: reads every diagnostic code, then arm clears and reset.
  assumes the host model's frame task and a bound checker.
*/
`timescale 1ns/1ps
`include "sdr_cfg.svh"

module squib_diag_readback_tb;
  logic       clk, rst_b, fireEnableOne, fireEnableTwo, resultStrobe;
  logic       firingSupplyBTested, voltageHighFlag, voltageLowFlag;
  logic       sclk, csB, mosi, miso, misoOe_b, armRequest;
  logic [7:0] channel1aTime, channel1bTime, channel2aTime, channel2bTime, lastCommand, rx;
  logic [3:0] currentLimit, lowSideThermalFlag, highSideThermalFlag, noGroundShort;
  logic [3:0] noBatteryShort, lowSideContinuity, openNoGroundShort, openNoBatteryShort;
  logic [3:0] diagnosticSupply2Level, diagnosticSupply1Level;
  logic [1:0] safingSensorLow, safingSensorHigh, diagSupplyHigh, diagSupplyLow;
  int         num_errors = 0;
  int         comparisons = 0;
  int         armCount = 0;
  // rows: command sent, answer due on the following frame
  logic [7:0] rowCmd [14] = '{8'h00, 8'h70, 8'h71, 8'h72, 8'h73, 8'h79, 8'h7F,
                              8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC5, 8'hC6, 8'h00};
  logic [7:0] rowExp [14] = '{8'h00, 8'h5A, 8'hC3, 8'h81, 8'h3E, 8'h09, 8'h6C,
                              8'hA6, 8'hB1, 8'h03, 8'h9C, 8'h12, 8'h7E, 8'h00};

  squib_diag_readback u_dut (.clk, .rst_b, .sclk, .csB, .mosi, .fireEnableOne,
    .fireEnableTwo, .resultStrobe, .channel1aTime, .channel1bTime, .channel2aTime,
    .channel2bTime, .currentLimit, .lowSideThermalFlag, .highSideThermalFlag,
    .safingSensorLow, .safingSensorHigh, .diagSupplyHigh, .diagSupplyLow, .noGroundShort,
    .noBatteryShort, .lowSideContinuity, .openNoGroundShort, .openNoBatteryShort,
    .firingSupplyBTested, .voltageHighFlag, .voltageLowFlag, .diagnosticSupply2Level,
    .diagnosticSupply1Level, .miso, .misoOe_b, .armRequest, .lastCommand);
  sdr_host_model u_host (.sclk(sclk), .csB(csB), .mosi(mosi), .miso(miso));

  // ----------------------------------------------------------------------
  // clock, inputs and helpers
  // ----------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // distinct patterns so a swapped field shows up
  initial
  begin
    {rst_b, fireEnableOne, fireEnableTwo, resultStrobe} <= 4'h0;
    {channel1aTime, channel1bTime, channel2aTime, channel2bTime} <= 32'h5AC3813E;
    {currentLimit, lowSideThermalFlag, highSideThermalFlag} <= 12'h96A;
    {safingSensorLow, safingSensorHigh, diagSupplyHigh, diagSupplyLow} <= 8'h9C;
    {noGroundShort, noBatteryShort, lowSideContinuity} <= 12'hC53;
    {openNoGroundShort, openNoBatteryShort} <= 8'hA6;
    {firingSupplyBTested, voltageHighFlag, voltageLowFlag} <= 3'h6;
    {diagnosticSupply2Level, diagnosticSupply1Level} <= 8'h7E;
  end

  always @(posedge clk)
    if (armRequest === 1'b1)
      armCount <= armCount + 1;

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // store loads on the strobe edge after its synchroniser
  task automatic pulse_strobe;
    @(posedge clk);
    resultStrobe <= 1'b1;
    repeat (4) @(posedge clk);
    resultStrobe <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  task automatic end_of_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    pulse_strobe();
    u_host.xfer(rowCmd[0], rx);
    check(rx, 8'h00);
    for (int i = 1; i < 14; i++)
    begin
      u_host.xfer(rowCmd[i], rx);
      check(rx, rowExp[i-1]);
    end
    u_host.xfer(8'h70, rx);
    check(rx, 8'h00);
    // refused arm raises no arm pulse, accepted arm wipes the results
    fireEnableOne <= 1'b1;
    repeat (8) @(posedge clk);
    u_host.xfer(`SDR_CMD_ARM_TWO, rx);
    check(rx, 8'h5A);
    check(8'(armCount), 8'h00);
    u_host.xfer(`SDR_CMD_ARM_ONE, rx);
    check(rx, `SDR_CMD_ARM_TWO);
    check(8'(armCount), 8'h01);
    u_host.xfer(8'h70, rx);
    check(rx, `SDR_CMD_ARM_ONE);
    u_host.xfer(8'h00, rx);
    check(rx, 8'h00);
    fireEnableTwo <= 1'b1;
    pulse_strobe();
    u_host.xfer(`SDR_CMD_ARM_ALL, rx);
    u_host.xfer(8'hC2, rx);
    u_host.xfer(8'h00, rx);
    check(rx, 8'h00);
    check(8'(armCount), 8'h02);
    // reset in mid-run drops the pending answer and last command
    pulse_strobe();
    u_host.xfer(8'h71, rx);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    // look between edges so the flop output has settled
    @(negedge clk);
    check(lastCommand, 8'h00);
    u_host.xfer(8'h00, rx);
    check(rx, 8'h00);
    end_of_test();
  end

  // whole run is about 24 frames of some 200 ns each
  initial
  begin
    #50000;
    num_errors++;
    end_of_test();
  end
endmodule
